// *** hdl/ric_top.sv ***
// Reset merging, interrupt arbitration and interrupt control registers.
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
module ric_top #(
  parameter int KEY_PINS   = 4,
  parameter int POD_CYCLES = ric_pkg::POD_CYCLES
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  // Reset sources and merged reset
  input  wire logic              reset_pin_n,
  input  wire logic              watchdog_timeout,
  output logic                   sync_rst,
  output logic                   mode_update,
  // Interrupt sources
  input  wire logic              ext_int_pin_n,
  input  wire logic [KEY_PINS-1:0] key_pins_n,
  input  wire logic              event_counter_interrupt,
  input  wire logic              serial_port_interrupt,
  input  wire logic              timebase_interrupt,
  // Processor core handshake
  input  wire logic              instr_done,
  input  wire logic              trap_fetch,
  input  wire logic              stack_done,
  input  wire logic              return_from_interrupt,
  output logic                   irq_req,
  output logic                   vector_valid,
  output logic [12:0]            vector_addr,
  output logic                   int_mask,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [7:0]        haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (KEY_PINS < 1 || KEY_PINS > 8) begin : g_bad_keys
    $error("KEY_PINS must be 1 to 8");
  end
  if (POD_CYCLES < 1 || POD_CYCLES > 16384) begin : g_bad_pod
    $error("POD_CYCLES must be 1 to 16384");
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0]          rpin_sync_r;
  logic [1:0]          epin_sync_r;
  logic [KEY_PINS-1:0] kpin_s1_r, kpin_s2_r, kpin_d_r;
  logic                epin_d_r;

  // Two flip-flops per pin before any logic reads it.
  always_ff @(posedge sys_clk) begin
    rpin_sync_r <= {rpin_sync_r[0], reset_pin_n};
    epin_sync_r <= {epin_sync_r[0], ext_int_pin_n};
    kpin_s1_r   <= key_pins_n;
    kpin_s2_r   <= kpin_s1_r;
    kpin_d_r    <= kpin_s2_r;
    epin_d_r    <= epin_sync_r[1];
  end

  wire pin_low     = ~rpin_sync_r[1];
  wire epin_fall   = epin_d_r & ~epin_sync_r[1];
  wire epin_low    = ~epin_sync_r[1];

  // ----------------------------------------------------------------
  // Reset merging
  // ----------------------------------------------------------------
  logic [13:0] pod_cnt_r;
  logic        pod_act_r;
  logic        wdog_sel_r;
  logic        pin_src_r, wd_src_r;
  logic        rst_latch_r;
  logic        mode_upd_r;

  wire wd_act  = watchdog_timeout & wdog_sel_r;
  wire any_src = pin_low | pod_act_r | wd_act;
  wire pod_end = pod_act_r && (pod_cnt_r == 14'(POD_CYCLES - 1));

  // Power-on delay counts from the first clock after power-up.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pod_cnt_r <= 14'h0000;
      pod_act_r <= 1'b1;
    end else if (pod_act_r) begin
      pod_cnt_r <= pod_cnt_r + 14'h0001;
      if (pod_end) pod_act_r <= 1'b0;
    end
  end

  // Latch follows any source and drops only when all have ended.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rst_latch_r <= 1'b1;
      pin_src_r   <= 1'b0;
      wd_src_r    <= 1'b0;
      mode_upd_r  <= 1'b0;
    end else begin
      rst_latch_r <= any_src;
      pin_src_r   <= (pin_src_r | pin_low) & any_src;
      wd_src_r    <= (wd_src_r | wd_act) & any_src;
      mode_upd_r  <= rst_latch_r & ~any_src & (pin_src_r | wd_src_r);
    end
  end

  wire rst_int = sys_rst | rst_latch_r;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic        ph_wr_r, ph_rd_r;
  logic [7:0]  ph_addr_r;
  logic [7:0]  ctrl_r;
  logic [7:0]  src_en_r;
  logic [KEY_PINS-1:0] key_pin_en_r;
  logic [31:0] rdata_r;

  wire addr_ok = hsel & hready & htrans[1];
  wire wr_stat = ph_wr_r && (ph_addr_r == ric_pkg::INT_STAT_ADDR);
  wire ext_clr = wr_stat & hwdata[ric_pkg::EXT_CLR_BIT];
  wire key_clr = wr_stat & hwdata[ric_pkg::KEY_CLR_BIT];

  // Capture the address phase for the following data phase.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ph_wr_r   <= 1'b0;
      ph_rd_r   <= 1'b0;
      ph_addr_r <= 8'h00;
    end else begin
      ph_wr_r   <= addr_ok & hwrite;
      ph_rd_r   <= addr_ok & ~hwrite;
      ph_addr_r <= haddr;
    end
  end

  // Writable controls; the merged reset clears them.
  always_ff @(posedge sys_clk) begin
    if (rst_int) begin
      ctrl_r       <= ric_pkg::INT_CTRL_RST;
      key_pin_en_r <= '0;
      src_en_r     <= 8'h00;
    end else if (ph_wr_r) begin
      case (ph_addr_r)
        ric_pkg::INT_CTRL_ADDR:   ctrl_r <= hwdata[7:0] & ric_pkg::INT_CTRL_MASK;
        ric_pkg::KEY_PIN_EN_ADDR: key_pin_en_r <= hwdata[KEY_PINS-1:0];
        ric_pkg::SRC_EN_ADDR:     src_en_r <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // The watchdog select survives the merged reset so a timeout can end.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) wdog_sel_r <= 1'b0;
    else if (ph_wr_r && ph_addr_r == ric_pkg::SRC_EN_ADDR)
      wdog_sel_r <= hwdata[ric_pkg::WDOG_SEL_BIT];
  end

  wire ext_en    = ctrl_r[ric_pkg::EXT_EN_BIT];
  wire key_en    = ctrl_r[ric_pkg::KEY_EN_BIT];
  wire edge_only = ctrl_r[ric_pkg::EDGE_ONLY_BIT];

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  logic                ext_flag_r;
  logic [KEY_PINS-1:0] key_latch_r;
  wire                 key_flag = |key_latch_r;
  wire [KEY_PINS-1:0]  key_fall = kpin_d_r & ~kpin_s2_r & key_pin_en_r;

  // Set wins over a clear in the same cycle.
  always_ff @(posedge sys_clk) begin
    if (rst_int) begin
      ext_flag_r  <= 1'b0;
      key_latch_r <= '0;
    end else begin
      ext_flag_r  <= epin_fall | (ext_flag_r & ~ext_clr);
      key_latch_r <= key_fall | (key_latch_r & {KEY_PINS{~key_clr}});
    end
  end

  // ----------------------------------------------------------------
  // Pending requests and priority
  // ----------------------------------------------------------------
  logic mask_r, mask_saved_r;
  wire ext_trig = ext_flag_r | (~edge_only & epin_low);
  wire ext_pend = ext_en & ext_trig;
  wire key_pend = key_en & key_flag;
  wire evt_pend = src_en_r[2] & event_counter_interrupt;
  wire spi_pend = src_en_r[1] & serial_port_interrupt;
  wire tb_pend  = src_en_r[0] & timebase_interrupt;
  wire hw_pend  = ext_pend | key_pend | evt_pend | spi_pend | tb_pend;

  logic [12:0] hw_vec;
  // Highest vector address first.
  always_comb begin
    if (ext_pend)      hw_vec = ric_pkg::VEC_EXT;
    else if (key_pend) hw_vec = ric_pkg::VEC_KEY;
    else if (evt_pend) hw_vec = ric_pkg::VEC_EVENT;
    else if (spi_pend) hw_vec = ric_pkg::VEC_SPI;
    else               hw_vec = ric_pkg::VEC_TIME;
  end

  // ----------------------------------------------------------------
  // Core sequencing
  // ----------------------------------------------------------------
  ric_pkg::ric_state_type state_r;
  logic        trap_pend_r, irq_r, vvalid_r;
  logic [12:0] vec_r;
  wire hw_take = hw_pend & ~mask_r;
  wire core_wr = ph_wr_r && (ph_addr_r == ric_pkg::CORE_ADDR);

  // Request at instruction end, vector once the core has stacked.
  always_ff @(posedge sys_clk) begin
    if (rst_int) begin
      state_r      <= ric_pkg::IDLE_ST;
      mask_r       <= 1'b1;
      mask_saved_r <= 1'b1;
      trap_pend_r  <= 1'b0;
      irq_r        <= 1'b0;
      vvalid_r     <= 1'b0;
      vec_r        <= ric_pkg::VEC_RESET;
    end else begin
      vvalid_r <= 1'b0;
      if (core_wr) mask_r <= hwdata[ric_pkg::MASK_BIT];
      if (trap_fetch) trap_pend_r <= 1'b1;
      case (state_r)
        ric_pkg::IDLE_ST: begin
          if (return_from_interrupt) begin
            mask_r <= mask_saved_r;
          end else if (instr_done && (hw_take || trap_pend_r)) begin
            irq_r   <= 1'b1;
            state_r <= ric_pkg::STACK_ST;
          end
        end
        ric_pkg::STACK_ST: begin
          if (stack_done) begin
            mask_saved_r <= mask_r;
            mask_r       <= 1'b1;
            irq_r        <= 1'b0;
            state_r      <= ric_pkg::VECTOR_ST;
          end
        end
        ric_pkg::VECTOR_ST: begin
          vvalid_r <= 1'b1;
          state_r  <= ric_pkg::IDLE_ST;
          if (hw_pend && !mask_saved_r) begin
            vec_r <= hw_vec;
          end else if (trap_pend_r) begin
            vec_r       <= ric_pkg::VEC_TRAP;
            trap_pend_r <= 1'b0;
          end else begin
            vvalid_r <= 1'b0;
          end
        end
        default: state_r <= ric_pkg::IDLE_ST;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire [7:0] stat_rd = {key_flag ? 8'h10 : 8'h00} | {ext_flag_r ? 8'h80 : 8'h00};
  logic [31:0] rd_mux;
  always_comb begin
    case (haddr)
      ric_pkg::INT_CTRL_ADDR:   rd_mux = {24'h000000, ctrl_r};
      ric_pkg::INT_STAT_ADDR:   rd_mux = {24'h000000, stat_rd};
      ric_pkg::KEY_PIN_EN_ADDR: rd_mux = 32'(key_pin_en_r);
      ric_pkg::SRC_EN_ADDR:     rd_mux = {24'h000000, src_en_r[7:5], wdog_sel_r,
                                          src_en_r[3:0]};
      ric_pkg::CORE_ADDR:       rd_mux = {18'h00000, mask_r, vec_r};
      default:                  rd_mux = 32'h00000000;
    endcase
  end

  // Read data is captured in the address phase for the data phase.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) rdata_r <= 32'h00000000;
    else if (addr_ok & ~hwrite) rdata_r <= rd_mux;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync_rst    <= 1'b1;
      mode_update <= 1'b0;
      irq_req     <= 1'b0;
      vector_valid<= 1'b0;
      vector_addr <= ric_pkg::VEC_RESET;
      int_mask    <= 1'b1;
    end else begin
      sync_rst    <= rst_latch_r;
      mode_update <= mode_upd_r;
      irq_req     <= irq_r;
      vector_valid<= vvalid_r;
      vector_addr <= vec_r;
      int_mask    <= mask_r;
    end
  end

  assign hrdata    = rdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule

// *** inc/ric_pkg.sv ***
// Constants and types shared by the reset and interrupt control block.
package ric_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on AHB-Lite)
  // ----------------------------------------------------------------
  localparam logic [7:0] INT_CTRL_ADDR   = 8'h00; // interrupt_control
  localparam logic [7:0] INT_STAT_ADDR   = 8'h04; // flags and flag clears
  localparam logic [7:0] KEY_PIN_EN_ADDR = 8'h08; // key_wake_pin_enables
  localparam logic [7:0] SRC_EN_ADDR     = 8'h0c; // peripheral enables, watchdog select
  localparam logic [7:0] CORE_ADDR       = 8'h10; // vector and mask status

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int EXT_EN_BIT      = 7;  // ext_int_enable
  localparam int KEY_EN_BIT      = 4;  // key_wake_enable
  localparam int EDGE_ONLY_BIT   = 3;  // ext_edge_only_select
  localparam int EXT_FLAG_BIT    = 7;  // ext_int_flag
  localparam int KEY_FLAG_BIT    = 4;  // key_wake_flag
  localparam int EXT_CLR_BIT     = 3;  // ext_flag_clear
  localparam int KEY_CLR_BIT     = 0;  // key_flag_clear
  localparam int WDOG_SEL_BIT    = 4;  // watchdog reset select
  localparam int MASK_BIT        = 13; // interrupt mask in the core status word
  localparam logic [7:0] INT_CTRL_RST = 8'h00;
  localparam logic [7:0] INT_CTRL_MASK = 8'h98; // bits 6-5 and 2-0 read zero

  // ----------------------------------------------------------------
  // Vector addresses
  // ----------------------------------------------------------------
  localparam logic [12:0] VEC_RESET = 13'h1ffe;
  localparam logic [12:0] VEC_TRAP  = 13'h1ffc;
  localparam logic [12:0] VEC_EXT   = 13'h1ffa;
  localparam logic [12:0] VEC_KEY   = 13'h1ff8;
  localparam logic [12:0] VEC_EVENT = 13'h1ff4;
  localparam logic [12:0] VEC_SPI   = 13'h1ff2;
  localparam logic [12:0] VEC_TIME  = 13'h1ff0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int POD_MIN_CYCLES = 8064; // least power-on delay in bus cycles
  localparam int POD_MAX_CYCLES = 8192; // longest power-on delay in bus cycles
  localparam int POD_CYCLES     = POD_MAX_CYCLES;

  // Core handshake states.
  typedef enum logic [1:0] {IDLE_ST, STACK_ST, VECTOR_ST} ric_state_type;

endpackage

// *** test/ric_core_model.sv ***
// Behavioural processor core that stacks registers when the block asks.
`timescale 1ns/100ps
module ric_core_model (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Handshake with the block
  input  wire logic irq_req,
  input  wire logic slow,
  output logic      stack_done
);
  initial stack_done = 1'b0;

  // Stacks promptly or slowly, then waits for the request to drop.
  always begin
    @(posedge sys_clk);
    if (sys_rst === 1'b0 && irq_req === 1'b1) begin
      repeat (slow ? 4 : 1) @(posedge sys_clk);
      stack_done <= 1'b1;
      @(posedge sys_clk);
      stack_done <= 1'b0;
      while (irq_req === 1'b1) @(posedge sys_clk);
    end
  end
endmodule

// *** test/ric_checker.sv ***
// Concurrent checks on the ports of the reset and interrupt control block.
`timescale 1ns/100ps
module ric_checker #(
  parameter int POD_CYCLES = 16
) (
  // Clock, reset and reset sources
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        reset_pin_n,
  input wire logic        watchdog_timeout,
  input wire logic        sync_rst,
  input wire logic        mode_update,
  // Core handshake
  input wire logic        instr_done,
  input wire logic        trap_fetch,
  input wire logic        stack_done,
  input wire logic        return_from_interrupt,
  input wire logic        irq_req,
  input wire logic        vector_valid,
  input wire logic [12:0] vector_addr,
  input wire logic        int_mask,
  // Register bus
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Cycles since release, whether pin or watchdog took part, mask before stacking.
  int   since_r;
  int   since_nxt;
  logic cause_r;
  logic cause_nxt;
  logic prev_mask_r;
  logic prev_mask_nxt;
  assign since_nxt = (since_r < POD_CYCLES) ? since_r + 1 : since_r;
  assign cause_nxt = (cause_r & ~mode_update) | (sync_rst & (~reset_pin_n | watchdog_timeout));
  assign prev_mask_nxt = stack_done ? int_mask : prev_mask_r;

  // Helper registers loaded by the bench reset: count and cause to zero, saved mask to one.
  always_ff @(posedge sys_clk) begin
    since_r     <= sys_rst ? 0 : since_nxt;
    cause_r     <= sys_rst ? 1'b0 : cause_nxt;
    prev_mask_r <= sys_rst ? 1'b1 : prev_mask_nxt;
  end

  sequence rd_at(logic [7:0] a);
    hsel && hready && htrans[1] && !hwrite && haddr == a;
  endsequence
  sequence trap_masked;
    trap_fetch && int_mask ##1 instr_done;
  endsequence

  a_pod_length: assert property ($fell(sync_rst) |-> since_r >= POD_CYCLES)
    else $error("merged reset ended before the power-on delay");
  a_pin_holds: assert property (!reset_pin_n [*5] |-> sync_rst)
    else $error("reset pin low but merged reset released");
  a_late_release: assert property ($fell(sync_rst) |-> $past(reset_pin_n, 4))
    else $error("merged reset ended while the pin was still low");
  a_mode_cause: assert property (mode_update |-> cause_r)
    else $error("mode update without pin or watchdog reset");
  a_req_after: assert property ($rose(irq_req) |-> $past(instr_done, 2))
    else $error("interrupt request not tied to instruction end");
  a_mask_stack: assert property (stack_done |-> ##[1:2] int_mask)
    else $error("mask not set after stacking");
  a_vec_masked: assert property (vector_valid |-> int_mask)
    else $error("vector given with mask clear");
  a_vec_table: assert property (vector_valid |-> vector_addr inside {13'h1ffc, 13'h1ffa,
    13'h1ff8, 13'h1ff4, 13'h1ff2, 13'h1ff0})
    else $error("vector outside the table");
  a_trap_taken: assert property (trap_masked |-> ##[2:30] vector_valid && vector_addr == 13'h1ffc)
    else $error("masked trap not vectored");
  a_rti_mask: assert property (return_from_interrupt |-> ##[1:2] int_mask == prev_mask_r)
    else $error("return did not restore the mask");
  a_reset_state: assert property ($fell(sync_rst) |-> int_mask && vector_addr == 13'h1ffe)
    else $error("reset did not load vector and mask");
  a_ctrl_zero: assert property (rd_at(8'h00) |=> (hrdata & 32'hffffff67) == 32'h0)
    else $error("unused control bits read nonzero");
  a_clear_zero: assert property (rd_at(8'h04) |=> !hrdata[3] && !hrdata[0])
    else $error("flag clear bits read nonzero");
endmodule

bind ric_top ric_checker #(.POD_CYCLES(POD_CYCLES)) u_ric_checker (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n),
  .watchdog_timeout(watchdog_timeout), .sync_rst(sync_rst), .mode_update(mode_update),
  .instr_done(instr_done), .trap_fetch(trap_fetch), .stack_done(stack_done),
  .return_from_interrupt(return_from_interrupt), .irq_req(irq_req),
  .vector_valid(vector_valid), .vector_addr(vector_addr), .int_mask(int_mask),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata)
);

// *** test/ric_top_test.sv ***
// Self-checking bench for the reset and interrupt control block.
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin errors++; \
  $display("unexpected %s expected %0h seen %0h", nm, ex, gt); end end
module ric_top_test;
  logic        sys_clk = 1'b0, sys_rst = 1'b1, reset_pin_n = 1'b1, watchdog_timeout = 1'b0;
  logic        ext_int_pin_n = 1'b1, instr_done = 1'b0, trap_fetch = 1'b0;
  logic        return_from_interrupt = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
  logic [3:0]  key_pins_n = 4'hf;
  logic [2:0]  lv = 3'h0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, rdat, hrdata, seed = 32'd61963;
  logic [12:0] vector_addr;
  logic        sync_rst, mode_update, irq_req, vector_valid, int_mask, hreadyout, hresp;
  logic        stack_done;
  int          errors = 0, n_tests = 0;

  initial forever #5 sys_clk = ~sys_clk;

  ric_top #(.POD_CYCLES(16)) u_ric_top (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n),
    .watchdog_timeout(watchdog_timeout), .sync_rst(sync_rst), .mode_update(mode_update),
    .ext_int_pin_n(ext_int_pin_n), .key_pins_n(key_pins_n), .event_counter_interrupt(lv[2]),
    .serial_port_interrupt(lv[1]), .timebase_interrupt(lv[0]), .instr_done(instr_done),
    .trap_fetch(trap_fetch), .stack_done(stack_done),
    .return_from_interrupt(return_from_interrupt), .irq_req(irq_req),
    .vector_valid(vector_valid), .vector_addr(vector_addr), .int_mask(int_mask),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp)
  );
  ric_core_model u_ric_core_model (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .irq_req(irq_req), .slow(slow),
    .stack_done(stack_done)
  );

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic bail(input bit hit);
    if (hit) begin
      errors++;
      results();
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Waits, bounded, for the bus ready or the merged reset to end.
  task automatic wait_on(input bit rdy);
    int i;
    i = 0;
    tick(1);
    while ((rdy ? hreadyout !== 1'b1 : sync_rst !== 1'b0) && i < 200) begin
      tick(1);
      i++;
    end
    bail(i == 200);
  endtask
  // One single AHB-Lite word transfer; read data lands in rdat.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    wait_on(1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_on(1'b1);
    rdat = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask
  // Ends an instruction, optionally a trap, and compares the vector served.
  task automatic service(input logic t, input logic [12:0] ex);
    int i;
    int lim;
    lim = (ex == 13'h0) ? 12 : 40;
    trap_fetch <= t;
    tick(1);
    trap_fetch <= 1'b0;
    instr_done <= 1'b1;
    tick(1);
    instr_done <= 1'b0;
    i = 0;
    while (vector_valid !== 1'b1 && i < lim) begin
      tick(1);
      i++;
    end
    `CHK("vector", ex, (i < lim) ? vector_addr : 13'h0)
    bail(ex != 13'h0 && i == lim);
    if (i < lim) begin
      return_from_interrupt <= 1'b1;
      tick(1);
      return_from_interrupt <= 1'b0;
    end
    tick(3);
  endtask
  // Reference arbiter: highest vector among pending sources, trap last.
  function automatic logic [12:0] exp_vec(input logic t, input logic [3:0] p);
    logic [12:0] tbl [4];
    tbl = '{13'h1ff0, 13'h1ff2, 13'h1ff4, 13'h1ffa};
    for (int i = 3; i >= 0; i--) if (p[i]) return tbl[i];
    return t ? 13'h1ffc : 13'h0;
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [3:0]  p;
    tick(10);
    sys_rst <= 1'b0;
    wait_on(1'b0);
    `CHK("mode_update", 1'b0, mode_update)
    `CHK("mask", 1'b1, int_mask)
    `CHK("vector", 13'h1ffe, vector_addr)
    bus(0, ric_pkg::INT_CTRL_ADDR, 0);
    `CHK("ctrl", 8'h00, rdat[7:0])
    bus(1, ric_pkg::INT_CTRL_ADDR, 32'hff);
    bus(0, ric_pkg::INT_CTRL_ADDR, 0);
    `CHK("ctrl", 8'h98, rdat[7:0])
    bus(1, 8'h40, 32'hff);
    bus(0, 8'h40, 0);
    `CHK("unmapped", 32'h0, rdat)
    bus(1, ric_pkg::INT_CTRL_ADDR, 0);
    $display("test registers finished");
    lv <= 3'h7;
    bus(1, ric_pkg::CORE_ADDR, 32'h2000);
    bus(1, ric_pkg::SRC_EN_ADDR, 32'h7);
    service(0, 13'h0);
    service(1, 13'h1ffc);
    bus(1, ric_pkg::CORE_ADDR, 32'h0);
    tick(2);
    `CHK("mask", 1'b0, int_mask)
    $display("test mask finished");
    for (int k = 0; k < 12; k++) begin
      seed = xs(seed);
      r = seed;
      slow <= r[8];
      lv <= r[6:4];
      bus(1, ric_pkg::SRC_EN_ADDR, {29'h0, r[2:0]});
      p = {1'b0, r[6:4] & r[2:0]};
      service(r[9], exp_vec(r[9], p));
      if (r[9] && p != 4'h0) begin
        lv <= 3'h0;
        service(0, 13'h1ffc);
      end
    end
    lv <= 3'h0;
    $display("test priority finished");
    for (int k = 0; k < 2; k++) begin
      bus(1, ric_pkg::INT_CTRL_ADDR, k ? 32'h80 : 32'h88);
      bus(1, ric_pkg::INT_STAT_ADDR, 32'h08);
      ext_int_pin_n <= 1'b0;
      tick(4);
      bus(0, ric_pkg::INT_STAT_ADDR, 0);
      `CHK("ext_flag", 8'h80, rdat[7:0])
      service(0, 13'h1ffa);
      bus(1, ric_pkg::INT_STAT_ADDR, 32'h08);
      service(0, k ? 13'h1ffa : 13'h0);
      ext_int_pin_n <= 1'b1;
      tick(2);
      bus(1, ric_pkg::INT_STAT_ADDR, 32'h08);
      bus(0, ric_pkg::INT_STAT_ADDR, 0);
      `CHK("ext_flag", 8'h00, rdat[7:0])
    end
    $display("test external finished");
    bus(1, ric_pkg::INT_CTRL_ADDR, 32'h10);
    bus(1, ric_pkg::KEY_PIN_EN_ADDR, 32'h01);
    key_pins_n <= 4'hd;
    tick(4);
    bus(0, ric_pkg::INT_STAT_ADDR, 0);
    `CHK("key_flag", 8'h00, rdat[7:0])
    key_pins_n <= 4'hc;
    tick(4);
    bus(0, ric_pkg::INT_STAT_ADDR, 0);
    `CHK("key_flag", 8'h10, rdat[7:0])
    service(0, 13'h1ff8);
    bus(1, ric_pkg::INT_STAT_ADDR, 32'h01);
    bus(0, ric_pkg::INT_STAT_ADDR, 0);
    `CHK("key_flag", 8'h00, rdat[7:0])
    key_pins_n <= 4'hf;
    $display("test key finished");
    bus(1, ric_pkg::SRC_EN_ADDR, 32'h0);
    watchdog_timeout <= 1'b1;
    tick(6);
    `CHK("sync_rst", 1'b0, sync_rst)
    watchdog_timeout <= 1'b0;
    bus(1, ric_pkg::SRC_EN_ADDR, 32'h10);
    watchdog_timeout <= 1'b1;
    reset_pin_n <= 1'b0;
    tick(6);
    `CHK("sync_rst", 1'b1, sync_rst)
    watchdog_timeout <= 1'b0;
    tick(6);
    `CHK("sync_rst", 1'b1, sync_rst)
    reset_pin_n <= 1'b1;
    wait_on(1'b0);
    `CHK("mode_update", 1'b1, mode_update)
    `CHK("mask", 1'b1, int_mask)
    bus(0, ric_pkg::INT_CTRL_ADDR, 0);
    `CHK("ctrl", 8'h00, rdat[7:0])
    $display("test resets finished");
    results();
  end
endmodule
